//--- design/adr_alarm_report.sv
// Purpose: alarm lamp, relay, error reporting, counters, event log, clock
// Assumes: inputs synchronous to clk; classic Wishbone register slave
// Notes:   ack one cycle after request; unmapped reads return zero
// Overview of operation
// R1: analog output scales temperature linearly, full scale at 300 or 500.
// R2: calibration-needed errors blink the lamp at four per second.
// R3: configuration errors blink the lamp at one per second.
// R4: start-blocking malfunctions keep the lamp lit continuously.
// R5: factory relay: off while blinking, on after start request, on steady.
// R6: non-factory relay setting inverts all relay states.
// R7: any error sets the alarm flag in cyclic status.
// R8: error number in bits 0..3 compact, bits 8..11 of word two otherwise.
// R9: during alarm, analog output shows one of thirteen error levels.
// R10: error n maps to n times 0.667 V on the analog output.
// R11: blink-class errors alternate analog output with full scale at 1 Hz.
// R12: start request during alternating holds the analog output steady.
// R13: alarm clears on falling edge of clear bit, or by power cycle.
// R14: master ignores alarms seen while the device powers down.
// R15: sealing cycles counted on start bit, readable, never reset; rstn clears the count to zero.
// R16: powered time accumulated in six-minute units, read only.
// R17: last 400 error and calibration events logged with timestamps.
// R18: clock set and read by master; unset clock stores invalid stamps.
// R19: blink and alternation use 50 percent duty from a clock divider.
`timescale 1ns/10ps
module adr_alarm_report #(
  parameter int unsigned TICK_CYC = adr_pkg::TICK_CYC
) (
  input  wire logic        clk,             // 20 MHz core clock
  input  wire logic        rstn,            // async reset, active low
  input  wire logic        wb_cyc_i,        // bus cycle
  input  wire logic        wb_stb_i,        // bus strobe
  input  wire logic        wb_we_i,         // write enable
  input  wire logic [7:0]  wb_adr_i,        // byte address
  input  wire logic [3:0]  wb_sel_i,        // byte lanes
  input  wire logic [31:0] wb_dat_i,        // write data
  output logic      [31:0] wb_dat_o,        // read data
  output logic             wb_ack_o,        // acknowledge
  input  wire logic [3:0]  errNum,          // reported error 1..13, 0 none
  input  wire logic [9:0]  errDetail,       // detailed error code
  input  wire logic        calDone,         // calibration finished pulse
  input  wire logic [9:0]  actualTemp,      // temperature in degrees
  input  wire logic        sealRequestBit,  // start bit from master
  input  wire logic        alarmClearBit,   // reset bit from master
  output logic             alarmFlag,       // cyclic alarm flag
  output logic             alarmLamp,       // red lamp drive
  output logic             alarmRelay,      // relay coil drive
  output logic      [11:0] aoutCode,        // analog output code
  output logic      [15:0] cyclicActual,    // cyclic word one
  output logic      [15:0] cyclicDiag       // cyclic word two
);
  localparam int AW = 9;
  localparam logic [AW-1:0] LOG_LAST = AW'(adr_pkg::LOG_DEPTH - 1);

  logic             tick8;
  logic [2:0]       phase_q, phase_d;
  logic [8:0]       minSec_q, minSec_d;
  logic [3:0]       ctrl_q, ctrl_d;
  logic             alarm_q, alarm_d;
  logic [3:0]       num_q, num_d;
  logic [9:0]       det_q, det_d;
  logic             startSeen_q, startSeen_d;
  logic             clrPrev_q, sealPrev_q;
  logic [31:0]      cycles_q, cycles_d;
  logic [31:0]      hours_q, hours_d;
  logic [31:0]      time_q, time_d;
  logic             timeOk_q, timeOk_d;
  logic [AW-1:0]    head_q, head_d, sel_q, sel_d;
  logic [AW-1:0]    count_q, count_d;
  logic             logWr;
  logic [46:0]      logEntry, logRd;
  adr_pkg::adr_cls_e cls;
  logic             wrAcc, rdAcc;
  logic [31:0]      wmask, rdVal;
  logic [29:0]      prod;
  logic [13:0]      scaled;
  logic [11:0]      tempCode, errLevel;
  logic             relayBase;

  adr_tick_div #(.DIV(TICK_CYC)) u_div (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick8)
  );

  adr_log_mem #(.DEPTH(adr_pkg::LOG_DEPTH), .WIDTH(adr_pkg::LOG_WIDTH),
                .AW(AW)) u_log (
    .clk    (clk),
    .wrEn   (logWr),
    .wrAddr (head_q),
    .wrData (logEntry),
    .rdAddr (sel_q),
    .rdData (logRd)
  );

  // classify latched error into lamp pattern class
  function automatic adr_pkg::adr_cls_e classify(input logic [3:0] n,
                                                 input logic [9:0] d);
    adr_pkg::adr_cls_e c;
    c = adr_pkg::CLS_STEADY;
    if (n == 4'h0) c = adr_pkg::CLS_NONE;
    else if (n == 4'h8 || n == 4'h9 || (d >= 10'd104 && d <= 10'd106) ||
             d == 10'd211 || d == 10'd302 || d == 10'd303)
      c = adr_pkg::CLS_FAST;                                   // R2
    else if ((n >= 4'hA && n <= 4'hC) || (d >= 10'd111 && d <= 10'd114))
      c = adr_pkg::CLS_SLOW;                                   // R3
    return c;
  endfunction

  assign cls   = alarm_q ? classify(num_q, det_q) : adr_pkg::CLS_NONE;
  assign wrAcc = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rdAcc = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // next state of alarm, counters, clock and log pointers
  always_comb begin
    phase_d     = tick8 ? phase_q + 3'h1 : phase_q;            // R19
    minSec_d    = minSec_q;
    hours_d     = hours_q;
    time_d      = time_q;
    timeOk_d    = timeOk_q;
    ctrl_d      = ctrl_q;
    sel_d       = sel_q;
    cycles_d    = cycles_q;
    alarm_d     = alarm_q;
    num_d       = num_q;
    det_d       = det_q;
    startSeen_d = startSeen_q;
    head_d      = head_q;
    count_d     = count_q;
    logWr       = 1'b0;
    logEntry    = '0;
    // seconds, six-minute units and clock
    if (tick8 && phase_q == 3'h7) begin
      time_d = time_q + 32'h0000_0001;
      if (minSec_q == 9'(adr_pkg::SIX_MIN_S - 1)) begin
        minSec_d = 9'h000;
        hours_d  = hours_q + 32'h0000_0001;                    // R16
      end else begin
        minSec_d = minSec_q + 9'h001;
      end
    end
    if (sealRequestBit && !sealPrev_q) begin
      cycles_d = cycles_q + 32'h0000_0001;                     // R15
    end
    // register writes
    if (wrAcc && wb_adr_i == adr_pkg::OFS_CTRL) begin
      ctrl_d = (ctrl_q & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
    end
    if (wrAcc && wb_adr_i == adr_pkg::OFS_TIME) begin
      time_d   = (time_q & ~wmask) | (wb_dat_i & wmask);       // R18
      timeOk_d = 1'b1;
    end
    if (wrAcc && wb_adr_i == adr_pkg::OFS_LOGSEL && wb_sel_i[0]) begin
      sel_d = (wb_dat_i[AW-1:0] > LOG_LAST) ? LOG_LAST : wb_dat_i[AW-1:0];
    end
    // alarm latch: clear acts on release of the clear bit
    if (alarm_q && clrPrev_q && !alarmClearBit) begin          // R13
      alarm_d     = 1'b0;
      num_d       = 4'h0;
      det_d       = 10'h000;
      startSeen_d = 1'b0;
    end
    if (errNum != 4'h0) begin
      alarm_d = 1'b1;                                          // R7
      num_d   = errNum;
      det_d   = errDetail;
    end
    if (alarm_d && sealRequestBit &&
        (cls == adr_pkg::CLS_FAST || cls == adr_pkg::CLS_SLOW)) begin
      startSeen_d = 1'b1;                                      // R5
    end
    // log new errors and calibration runs
    if ((errNum != 4'h0 && (!alarm_q || errNum != num_q)) || calDone) begin
      logWr    = 1'b1;                                         // R17
      logEntry = {(errNum == 4'h0), errNum, errDetail,
                  timeOk_q ? time_q : adr_pkg::TIME_INVALID};  // R18
      head_d   = (head_q == LOG_LAST) ? '0 : head_q + AW'(1);
      count_d  = (count_q == AW'(adr_pkg::LOG_DEPTH)) ? count_q
                                                       : count_q + AW'(1);
    end
  end

  // temperature scaling and error level
  always_comb begin
    prod     = actualTemp * (ctrl_q[adr_pkg::CTRL_RANGE_BIT] ?
                             adr_pkg::K_HI : adr_pkg::K_LO);
    scaled   = prod[adr_pkg::SCALE_SHIFT +: 14];
    tempCode = (scaled > 14'(adr_pkg::DAC_FS)) ? adr_pkg::DAC_FS
                                               : scaled[11:0];  // R1
    errLevel = 12'(num_q * adr_pkg::DAC_STEP);                 // R10
  end

  // register read mux
  always_comb begin
    unique case (wb_adr_i)
      adr_pkg::OFS_CTRL:    rdVal = {28'h000_0000, ctrl_q};
      adr_pkg::OFS_STATUS:  rdVal = {2'h0, count_q, head_q,
                                     timeOk_q, startSeen_q, cls,
                                     num_q, alarm_q, 3'h0};
      adr_pkg::OFS_CYCLES:  rdVal = cycles_q;
      adr_pkg::OFS_HOURS:   rdVal = hours_q;
      adr_pkg::OFS_TIME:    rdVal = time_q;
      adr_pkg::OFS_LOGSEL:  rdVal = {23'h00_0000, sel_q};
      adr_pkg::OFS_LOGTIME: rdVal = logRd[31:0];
      adr_pkg::OFS_LOGCODE: rdVal = {17'h0_0000, logRd[46:32]};
      default:              rdVal = adr_pkg::ZERO32;
    endcase
  end

  // relay base state for factory setting
  always_comb begin
    unique case (cls)
      adr_pkg::CLS_FAST,
      adr_pkg::CLS_SLOW:   relayBase = startSeen_q;            // R5
      adr_pkg::CLS_STEADY: relayBase = 1'b1;
      default:             relayBase = 1'b0;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q     <= 3'h0;
      minSec_q    <= 9'h000;
      hours_q     <= 32'h0000_0000;
      time_q      <= 32'h0000_0000;
      timeOk_q    <= 1'b0;
      ctrl_q      <= adr_pkg::CTRL_RESET;
      sel_q       <= '0;
      cycles_q    <= 32'h0000_0000;
      alarm_q     <= 1'b0;
      num_q       <= 4'h0;
      det_q       <= 10'h000;
      startSeen_q <= 1'b0;
      head_q      <= '0;
      count_q     <= '0;
      clrPrev_q   <= 1'b0;
      sealPrev_q  <= 1'b0;
    end else begin
      phase_q     <= phase_d;
      minSec_q    <= minSec_d;
      hours_q     <= hours_d;
      time_q      <= time_d;
      timeOk_q    <= timeOk_d;
      ctrl_q      <= ctrl_d;
      sel_q       <= sel_d;
      cycles_q    <= cycles_d;
      alarm_q     <= alarm_d;
      num_q       <= num_d;
      det_q       <= det_d;
      startSeen_q <= startSeen_d;
      head_q      <= head_d;
      count_q     <= count_d;
      clrPrev_q   <= alarmClearBit;
      sealPrev_q  <= sealRequestBit;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      alarmFlag    <= 1'b0;
      alarmLamp    <= 1'b0;
      alarmRelay   <= 1'b0;
      aoutCode     <= 12'h000;
      cyclicActual <= 16'h0000;
      cyclicDiag   <= 16'h0000;
    end else begin
      wb_ack_o   <= wrAcc || rdAcc;
      wb_dat_o   <= rdAcc ? rdVal : 32'h0000_0000;
      alarmFlag  <= alarm_q;                                   // R7
      alarmRelay <= relayBase ^ ctrl_q[adr_pkg::CTRL_RINV_BIT];  // R6
      unique case (cls)
        adr_pkg::CLS_FAST: alarmLamp <= phase_q[0];            // R2
        adr_pkg::CLS_SLOW: alarmLamp <= phase_q[2];            // R3
        adr_pkg::CLS_STEADY: alarmLamp <= 1'b1;                // R4
        default: alarmLamp <= 1'b0;
      endcase
      if (!alarm_q) aoutCode <= tempCode;                      // R1
      else if (cls == adr_pkg::CLS_STEADY || startSeen_q)
        aoutCode <= errLevel;                                  // R9 R12
      else aoutCode <= phase_q[2] ? adr_pkg::DAC_FS : errLevel;  // R11
      if (alarm_q && ctrl_q[adr_pkg::CTRL_PROT_LSB +: 2] ==
          adr_pkg::PROT_COMPACT)
        cyclicActual <= 16'(num_q) << adr_pkg::ERRNUM_COMPACT_LSB;  // R8
      else cyclicActual <= 16'(actualTemp);
      if (ctrl_q[adr_pkg::CTRL_PROT_LSB +: 2] != adr_pkg::PROT_COMPACT)
        cyclicDiag <= 16'(num_q) << adr_pkg::ERRNUM_WORD2_LSB;     // R8
      else cyclicDiag <= 16'h0000;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_flag_follows_alarm: assert property (                      // R7
    errNum != 4'h0 |-> ##2 alarmFlag)
    else $error("alarm flag not set during alarm");
  a_clear_on_release: assert property (                        // R13
    alarm_q && clrPrev_q && !alarmClearBit && errNum == 4'h0 |=> !alarm_q)
    else $error("alarm not cleared on release of clear bit");
  a_hold_while_clear: assert property (                        // R13
    alarm_q && alarmClearBit |=> alarm_q)
    else $error("alarm cleared while clear bit active");
  a_steady_lamp_on: assert property (                          // R4
    cls == adr_pkg::CLS_STEADY |=> alarmLamp)
    else $error("steady lamp not lit");
  a_fast_lamp_phase: assert property (                         // R2
    cls == adr_pkg::CLS_FAST |=> alarmLamp == $past(phase_q[0]))
    else $error("fast blink out of phase");
  a_relay_steady_state: assert property (                      // R6
    cls == adr_pkg::CLS_STEADY
      |=> alarmRelay == !$past(ctrl_q[adr_pkg::CTRL_RINV_BIT]))
    else $error("relay wrong in steady alarm");
  a_level_per_number: assert property (                        // R10
    cls == adr_pkg::CLS_STEADY ##1 cls == adr_pkg::CLS_STEADY
      |-> aoutCode == 12'($past(num_q) * adr_pkg::DAC_STEP))
    else $error("analog error level wrong");
  a_start_holds_level: assert property (                       // R12
    startSeen_q && alarm_q |=> aoutCode == $past(errLevel))
    else $error("analog output alternates after start");
  a_cycle_increment: assert property (                         // R15
    sealRequestBit && !sealPrev_q |=> cycles_q == $past(cycles_q) + 1)
    else $error("sealing cycle not counted");
  a_invalid_stamp: assert property (                           // R18
    logWr && !timeOk_q |-> logEntry[31:0] == adr_pkg::TIME_INVALID)
    else $error("unset clock stored valid stamp");

  c_fast_blink: cover property (cls == adr_pkg::CLS_FAST ##1 startSeen_q);
  c_slow_blink: cover property (cls == adr_pkg::CLS_SLOW && tick8);
  c_alarm_clear: cover property (alarm_q ##1 !alarm_q);
  c_log_full: cover property (count_q == AW'(adr_pkg::LOG_DEPTH));
endmodule

//--- design/adr_log_mem.sv
// Purpose: event log storage with registered read data
// Assumes: one write port, one read port, same clock
// Notes:   read data follows the read address by one cycle
`timescale 1ns/10ps
module adr_log_mem #(
  parameter int unsigned DEPTH = 400,
  parameter int unsigned WIDTH = 47,
  parameter int unsigned AW    = 9
) (
  input  wire logic             clk,     // core clock
  input  wire logic             wrEn,    // write strobe
  input  wire logic [AW-1:0]    wrAddr,  // write index
  input  wire logic [WIDTH-1:0] wrData,  // entry to store
  input  wire logic [AW-1:0]    rdAddr,  // read index
  output logic      [WIDTH-1:0] rdData   // registered entry
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write and registered read
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

//--- design/adr_pkg.sv
// Purpose: shared constants for the alarm and diagnostic reporting block
// Assumes: 20 MHz core clock, 32-bit classic Wishbone register access
// Notes:   register offsets are byte addresses of aligned words
package adr_pkg;
  // clock and derived timing
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned TICK_HZ    = 8;      // base blink tick rate
  localparam int unsigned TICK_CYC   = CLK_HZ / TICK_HZ;
  localparam int unsigned SIX_MIN_S  = 360;    // operating hour resolution
  localparam int unsigned LOG_DEPTH  = 400;
  localparam int unsigned LOG_WIDTH  = 47;

  // register offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_CYCLES   = 8'h08;
  localparam logic [7:0] OFS_HOURS    = 8'h0C;
  localparam logic [7:0] OFS_TIME     = 8'h10;
  localparam logic [7:0] OFS_LOGSEL   = 8'h14;
  localparam logic [7:0] OFS_LOGTIME  = 8'h18;
  localparam logic [7:0] OFS_LOGCODE  = 8'h1C;

  // control fields
  localparam int CTRL_RANGE_BIT = 0;   // 1 = 500 degree full scale
  localparam int CTRL_RINV_BIT  = 1;   // relay inverted from factory
  localparam int CTRL_PROT_LSB  = 2;   // 2-bit protocol select
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // cyclic data fields
  localparam int ERRNUM_COMPACT_LSB = 0;
  localparam int ERRNUM_WORD2_LSB   = 8;

  // analog output scaling, 12-bit converter
  localparam logic [11:0] DAC_FS    = 12'hFFF;
  localparam int unsigned LEVELS    = 15;     // 10 V / 0.667 V steps
  localparam logic [11:0] DAC_STEP  = 12'(4095 / LEVELS);
  localparam int unsigned RANGE_LO  = 300;
  localparam int unsigned RANGE_HI  = 500;
  localparam logic [19:0] K_LO      = 20'((4095 * 65536) / RANGE_LO);
  localparam logic [19:0] K_HI      = 20'((4095 * 65536) / RANGE_HI);
  localparam int SCALE_SHIFT        = 16;

  localparam logic [31:0] TIME_INVALID = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO32       = 32'h0000_0000;

  typedef enum logic [1:0] {PROT_COMPACT, PROT_EXPANDED, PROT_COMPLETE,
                            PROT_SPARE} adr_prot_e;
  typedef enum logic [1:0] {CLS_NONE, CLS_FAST, CLS_SLOW,
                            CLS_STEADY} adr_cls_e;
endpackage

//--- design/adr_tick_div.sv
// Purpose: divides the core clock into a one-cycle enable pulse
// Assumes: single clock domain
// Notes:   pulse period is DIV cycles
`timescale 1ns/10ps
module adr_tick_div #(
  parameter int unsigned DIV = 2_500_000
) (
  input  wire logic clk,    // core clock
  input  wire logic rstn,   // async reset, active low
  output logic      tick    // one-cycle enable
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_d;

  // count up and pulse on wrap
  always_comb begin
    tick_d = (cnt_q == 32'(DIV - 1));
    cnt_d  = tick_d ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule

//--- test/adr_alarm_report_tb_top.sv
// Purpose: self-checking bench for alarm and diagnostic reporting
// Assumes: shortened tick divider, classic Wishbone single cycles
// Notes:   outputs are sampled at edges before that edge's updates land
`timescale 1ns/10ps
module adr_alarm_report_tb_top;
  localparam int TK   = 4;
  localparam int UNIT = 360 * 8 * TK;
  logic        clk, rstn, cyc, stb, we, calDone, seal, clr, seen, ack;
  logic        flag, lamp, relay;
  logic [7:0]  adr;
  logic [3:0]  sel, errNum, busSel;
  logic [9:0]  det, temp;
  logic [31:0] wdat, rdat, r;
  logic [11:0] aout, a;
  logic [15:0] cAct, cDiag;
  int          num_errors, total_checks, ncyc, hi, tog, fs, lv;

  adr_alarm_report #(.TICK_CYC(TK)) dut (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .errNum(errNum), .errDetail(det),
    .calDone(calDone), .actualTemp(temp), .sealRequestBit(seal),
    .alarmClearBit(clr), .alarmFlag(flag), .alarmLamp(lamp),
    .alarmRelay(relay), .aoutCode(aout), .cyclicActual(cAct),
    .cyclicDiag(cDiag));
  adr_master_model master (
    .clk(clk), .rstn(rstn), .alarmFlag(flag), .sealRequestBit(seal),
    .alarmClearBit(clr), .alarmSeen(seen));

  // 50 ns clock and cycle count
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) ncyc++;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one classic cycle; read data lands in r at the ack edge
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= busSel;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        chk(0, 1, "bus timeout");
        report_and_stop();
      end
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // apply an error number and let it settle
  task automatic err(input logic [3:0] n);
    @(posedge clk);
    errNum <= n;
    repeat (4) @(posedge clk);
  endtask
  // drop the error and clear the alarm
  task automatic clear_all();
    err(4'h0);
    master.clear(2);
    repeat (4) @(posedge clk);
  endtask
  // 64 samples of lamp and analog output against level l
  task automatic watch(input logic [11:0] l);
    logic last;
    hi = 0;
    tog = 0;
    fs = 0;
    lv = 0;
    @(posedge clk);
    last = lamp;
    repeat (64) begin
      @(posedge clk);
      hi += int'(lamp);
      tog += int'(lamp != last);
      fs += int'(aout === 12'hFFF);
      lv += int'(aout === l);
      last = lamp;
    end
  endtask
  function automatic logic [31:0] texp(input int t, rng);
    return 32'((t * ((4095 * 65536) / rng)) >> 16);
  endfunction

  initial begin
    {cyc, stb, we, calDone, errNum, det, adr, wdat} = '0;
    sel = 4'hF;
    busSel = 4'hF;
    temp = 10'd150;
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // reset values, unmapped place, linear temperature
    bus(0, adr_pkg::OFS_CTRL, 0);
    chk(r, 0, "ctrl reset");
    busSel = 4'hE;
    bus(1, adr_pkg::OFS_CTRL, 32'h0000_000F);
    busSel = 4'hF;
    bus(0, adr_pkg::OFS_CTRL, 0);
    chk(r, 0, "lane mask");
    bus(1, 8'h20, 32'hFFFF_FFFF);
    bus(0, 8'h20, 0);
    chk(r, 0, "unmapped");
    chk(aout, texp(150, 300), "temp 300");
    bus(0, adr_pkg::OFS_HOURS, 0);
    chk(r, 0, "hours start");
    // steady malfunction, clear refused while error present
    det <= 10'd101;
    err(4'h1);
    chk({flag, lamp, relay}, 3'b111, "steady");
    chk(seen, 1, "seen");
    chk(aout, 273, "level 1");
    chk(cAct[3:0], 1, "compact");
    master.clear(2);
    repeat (40) @(posedge clk);
    chk({flag, lamp}, 2'b11, "set wins");
    err(4'h0);
    master.clear(3);
    chk(flag, 1, "clear on assert");
    repeat (4) @(posedge clk);
    chk({flag, lamp, relay}, 0, "cleared");
    // log: invalid stamp, then stamped calibration
    bus(1, adr_pkg::OFS_TIME, 32'h0000_1234);
    @(posedge clk);
    calDone <= 1'b1;
    @(posedge clk);
    calDone <= 1'b0;
    bus(1, adr_pkg::OFS_LOGSEL, 0);
    bus(0, adr_pkg::OFS_LOGTIME, 0);
    chk(r, adr_pkg::TIME_INVALID, "unset stamp");
    bus(0, adr_pkg::OFS_LOGCODE, 0);
    chk(r, 32'h0000_0465, "log code");
    bus(1, adr_pkg::OFS_LOGSEL, 1);
    bus(0, adr_pkg::OFS_LOGTIME, 0);
    chk(r inside {[32'h1234 : 32'h1235]}, 1, "stamp");
    bus(0, adr_pkg::OFS_LOGCODE, 0);
    chk(r[14], 1, "cal entry");
    bus(0, adr_pkg::OFS_TIME, 0);
    chk(r inside {[32'h1234 : 32'h1236]}, 1, "time read");
    // error levels of steady errors
    for (int n = 1; n <= 13; n++) begin
      if (n < 8 || n == 13) begin
        err(4'(n));
        chk(aout, 32'(n * 273), "level");
        chk(cAct[3:0], 32'(n), "compact num");
      end
    end
    bus(1, adr_pkg::OFS_CTRL, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(cDiag[11:8], 13, "expanded");
    bus(1, adr_pkg::OFS_CTRL, 32'h0000_0008);
    err(4'h5);
    chk(cDiag[11:8], 5, "complete");
    bus(1, adr_pkg::OFS_CTRL, 0);
    clear_all();
    // fast blink, alternation, start freezes output
    err(4'h8);
    watch(12'(8 * 273));
    chk(hi, 32, "fast on");
    chk(tog, 16, "fast toggles");
    chk(fs, 32, "alt fast full");
    chk(lv, 32, "alt fast level");
    chk(relay, 0, "relay fast");
    master.seal(2);
    repeat (4) @(posedge clk);
    chk(relay, 1, "relay start");
    a = aout;
    repeat (40) @(posedge clk);
    chk(aout, a, "frozen");
    clear_all();
    // slow blink
    err(4'hA);
    watch(12'(10 * 273));
    chk(hi, 32, "slow on");
    chk(tog, 4, "slow toggles");
    chk(fs, 32, "alt slow full");
    chk(lv, 32, "alt slow level");
    chk(relay, 0, "relay slow");
    clear_all();
    // inverted relay, 500 degree range
    bus(1, adr_pkg::OFS_CTRL, 32'h0000_0003);
    temp <= 10'd250;
    repeat (4) @(posedge clk);
    chk(relay, 1, "inv idle");
    chk(aout, texp(250, 500), "temp 500");
    err(4'hA);
    chk(relay, 1, "inv slow");
    err(4'h3);
    chk(relay, 0, "inv steady");
    clear_all();
    // cycle count, never reset; hours read only
    master.seal(1);
    master.seal(3);
    bus(1, adr_pkg::OFS_CYCLES, 0);
    bus(0, adr_pkg::OFS_CYCLES, 0);
    chk(r, 3, "cycles");
    bus(1, adr_pkg::OFS_HOURS, 5);
    while (ncyc < UNIT + 300) @(posedge clk);
    bus(0, adr_pkg::OFS_HOURS, 0);
    chk(r, 1, "hours");
    report_and_stop();
  end
endmodule

//--- test/adr_master_model.sv
// Purpose: fieldbus master stand-in driving the start and clear bits
// Assumes: bits change only right after a rising clock edge
// Notes:   an alarm flag seen while power is off is not trusted
`timescale 1ns/10ps
module adr_master_model (
  input  wire logic clk,            // core clock
  input  wire logic rstn,           // power good, active high
  input  wire logic alarmFlag,      // cyclic alarm flag
  output logic      sealRequestBit, // start bit
  output logic      alarmClearBit,  // reset bit
  output logic      alarmSeen       // flag taken as valid
);
  // both bits idle low from power-up
  initial begin
    sealRequestBit = 1'b0;
    alarmClearBit  = 1'b0;
  end
  // flag is ignored while the device is down
  assign alarmSeen = rstn & alarmFlag;
  // one sealing cycle, start bit held for len cycles
  task automatic seal(input int len);
    @(posedge clk);
    sealRequestBit <= 1'b1;
    repeat (len) @(posedge clk);
    sealRequestBit <= 1'b0;
  endtask
  // clear request: raise, hold, then release
  task automatic clear(input int len);
    @(posedge clk);
    alarmClearBit <= 1'b1;
    repeat (len) @(posedge clk);
    alarmClearBit <= 1'b0;
  endtask
endmodule
